// *** include/tpid_defines.vh ***
// Constants for the test port identification block
`ifndef TPID_DEFINES_VH
`define TPID_DEFINES_VH

// Identification field positions
`define TPID_VARIANT_MSB   31
`define TPID_VARIANT_LSB   28
`define TPID_PART_MSB      27
`define TPID_PART_LSB      12
`define TPID_MFR_MSB       11
`define TPID_MFR_LSB       1
`define TPID_FIXED_ONE_BIT 0

// Identification code defaults (arbitrary values, not any real part)
`define TPID_VARIANT_RST   4'h2
`define TPID_PART_RST      16'h1234
`define TPID_MFR_RST       11'h055

// Instruction register
`define TPID_IR_WIDTH      4
`define TPID_IR_IDCODE     4'h1
`define TPID_IR_BYPASS     4'hF
`define TPID_IR_CAPTURE    4'h1

// Register port offsets (the id register sits at offset 0)
`define TPID_OFS_ID        4'h0
`define TPID_OFS_STATUS    4'h1
`define TPID_OFS_CTRL      4'h2

// Control reset value
`define TPID_CTRL_RST      2'h3

`endif

// *** design/tpid_top.v ***
// Test access port with device identification register
//
// Operation
// - Port serves boundary-scan and emulation access
// - Read-only 32-bit identification register
// - Variant code in bits 31:28
// - Part number in bits 27:12
// - Manufacturer code in bits 11:1
// - Test reset held asserted by default
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "tpid_defines.vh"

module tpid_top
#(
   parameter [3:0]  VARIANT = `TPID_VARIANT_RST,   // Arbitrary value
   parameter [15:0] PART    = `TPID_PART_RST,      // Arbitrary value
   parameter [10:0] MFR     = `TPID_MFR_RST        // Arbitrary value
)
(
   // System clock and reset
   input  wire        clk,
   input  wire        rst_b,
   // Test link pins
   input  wire        tck,
   input  wire        tms,
   input  wire        tdi,
   input  wire        trst_b,
   output reg         tdo,
   output reg         tdo_oe,
   // Register port
   input  wire [3:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // Emulation and boundary-scan selects
   output reg         emu_sel,
   output reg         bscan_sel
);

   // ****************************************
   // Local constants
   // ****************************************
   // Controller states; the codes also appear in the status word,
   // so software sees the same numbers as the state walk
   localparam [3:0] ST_RESET  = 4'h0;
   localparam [3:0] ST_IDLE   = 4'h1;
   localparam [3:0] ST_SEL_DR = 4'h2;
   localparam [3:0] ST_CAP_DR = 4'h3;
   localparam [3:0] ST_SH_DR  = 4'h4;
   localparam [3:0] ST_EX1_DR = 4'h5;
   localparam [3:0] ST_PA_DR  = 4'h6;
   localparam [3:0] ST_EX2_DR = 4'h7;
   localparam [3:0] ST_UP_DR  = 4'h8;
   localparam [3:0] ST_SEL_IR = 4'h9;
   localparam [3:0] ST_CAP_IR = 4'hA;
   localparam [3:0] ST_SH_IR  = 4'hB;
   localparam [3:0] ST_EX1_IR = 4'hC;
   localparam [3:0] ST_PA_IR  = 4'hD;
   localparam [3:0] ST_EX2_IR = 4'hE;
   localparam [3:0] ST_UP_IR  = 4'hF;

   // Fixed identification word
   // Built from parameters only, so no write path can ever reach it
   // and every field reads back the same in every state
   wire [31:0] id_word;                         // Composed id code
   assign id_word[`TPID_VARIANT_MSB:`TPID_VARIANT_LSB] = VARIANT;
   assign id_word[`TPID_PART_MSB:`TPID_PART_LSB]       = PART;
   assign id_word[`TPID_MFR_MSB:`TPID_MFR_LSB]         = MFR;
   assign id_word[`TPID_FIXED_ONE_BIT]                 = 1'b1;

   // ****************************************
   // Reset release
   // ****************************************
   reg rst_m_q;                                 // First reset stage
   reg rst_s_q;                                 // Synchronous reset copy

   // Release reset through two flops
   // Assertion is asynchronous so the block clears without a clock;
   // release is synchronous so no flop leaves reset a cycle early
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_m_q <= 1'b0;
         rst_s_q <= 1'b0;
      end
      else
      begin
         rst_m_q <= 1'b1;
         rst_s_q <= rst_m_q;
      end
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   reg [3:0] pin_m_q;                           // First stage, read by second only
   reg [3:0] pin_s_q;                           // Second stage {trst,tdi,tms,tck}
   reg       tck_old_q;                         // Previous sampled test clock

   // Two flops for every test pin; test reset idles asserted
   // The link clock is only sampled, so it must stay well below clk:
   // each phase has to last at least two clk periods or edges are lost.
   // Clearing the test reset stage to low stands in for the pin pulldown.
   always @(posedge clk or negedge rst_s_q)
   begin
      if (!rst_s_q)
      begin
         pin_m_q   <= 4'h0;
         pin_s_q   <= 4'h0;
         tck_old_q <= 1'b0;
      end
      else
      begin
         pin_m_q   <= {trst_b, tdi, tms, tck};
         pin_s_q   <= pin_m_q;
         tck_old_q <= pin_s_q[0];
      end
   end

   wire tms_s  = pin_s_q[1];                    // Synced mode select
   wire tdi_s  = pin_s_q[2];                    // Synced data in
   wire trst_s = pin_s_q[3];                    // Synced test reset, low active
   // Edge enables last one clk cycle; the old copy resets to the idle
   // low level of the pin so no false edge follows reset
   wire tck_r  = pin_s_q[0] & ~tck_old_q;       // Rising edge enable
   wire tck_f  = ~pin_s_q[0] & tck_old_q;       // Falling edge enable

   // ****************************************
   // Controller state machine
   // ****************************************
   reg [3:0] st_q;                              // Controller state
   reg [3:0] st_d;                              // Next state

   // Standard sixteen-state walk on mode select
   // Purely combinational; the state only moves on a link clock rise or on test reset,
   // and five rises with mode select high always reach the reset state
   always @*
   begin
      case (st_q)
         ST_RESET:  st_d = tms_s ? ST_RESET  : ST_IDLE;
         ST_IDLE:   st_d = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: st_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: st_d = tms_s ? ST_UP_DR  : ST_PA_DR;
         ST_PA_DR:  st_d = tms_s ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: st_d = tms_s ? ST_UP_DR  : ST_SH_DR;
         ST_UP_DR:  st_d = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: st_d = tms_s ? ST_RESET  : ST_CAP_IR;
         ST_CAP_IR: st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: st_d = tms_s ? ST_UP_IR  : ST_PA_IR;
         ST_PA_IR:  st_d = tms_s ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: st_d = tms_s ? ST_UP_IR  : ST_SH_IR;
         ST_UP_IR:  st_d = tms_s ? ST_SEL_DR : ST_IDLE;
         default:   st_d = ST_RESET;
      endcase
   end

   // ****************************************
   // Shift paths
   // ****************************************
   reg [`TPID_IR_WIDTH-1:0] ir_sh_q;            // Instruction shifter
   reg [`TPID_IR_WIDTH-1:0] ir_q;               // Current instruction
   reg [31:0]               dr_q;               // Id shifter
   reg                      byp_q;              // Bypass bit

   // Any instruction other than the id code selects the one-bit bypass
   // path, so unknown codes still give a defined one-stage path
   wire sel_id = (ir_q == `TPID_IR_IDCODE);     // Id register selected

   // Advance on test clock rising edge; test reset overrides everything
   // Capture reloads the id word on every pass, so a scan can never
   // leave changed contents behind for the next one
   always @(posedge clk or negedge rst_s_q)
   begin
      if (!rst_s_q)
      begin
         st_q    <= ST_RESET;
         ir_q    <= `TPID_IR_IDCODE;
         ir_sh_q <= {`TPID_IR_WIDTH{1'b0}};
         dr_q    <= 32'h00000000;
         byp_q   <= 1'b0;
      end
      else if (!trst_s)
      begin
         st_q <= ST_RESET;
         ir_q <= `TPID_IR_IDCODE;
      end
      else if (tck_r)
      begin
         st_q <= st_d;
         case (st_q)
            ST_RESET:  ir_q    <= `TPID_IR_IDCODE;
            ST_CAP_IR: ir_sh_q <= `TPID_IR_CAPTURE;
            ST_SH_IR:  ir_sh_q <= {tdi_s, ir_sh_q[`TPID_IR_WIDTH-1:1]};
            ST_UP_IR:  ir_q    <= ir_sh_q;
            ST_CAP_DR:
            begin
               dr_q  <= id_word;
               byp_q <= 1'b0;
            end
            ST_SH_DR:
            begin
               dr_q  <= {tdi_s, dr_q[31:1]};
               byp_q <= tdi_s;
            end
            default:   ir_q <= ir_q;            // Other states hold
         endcase
      end
   end

   // ****************************************
   // Test data out
   // ****************************************
   // Changes on the falling test clock edge, driven only while shifting
   // Launching on the fall gives the far side half a link period of
   // setup before its next rise; the cost is the sampling delay of
   // about three clk periods after the pin edge
   always @(posedge clk or negedge rst_s_q)
   begin
      if (!rst_s_q)
      begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (!trst_s)
      begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (tck_f)
      begin
         tdo_oe <= (st_q == ST_SH_DR) || (st_q == ST_SH_IR);
         if (st_q == ST_SH_IR)
            tdo <= ir_sh_q[0];
         else
            tdo <= sel_id ? dr_q[0] : byp_q;
      end
   end

   // ****************************************
   // Register port
   // ****************************************
   // Both enables come out of reset set, so a debugger finds the port
   // open as soon as it lets go of test reset
   reg [1:0] ctrl_q;                            // Emulation and scan enables

   // Control register write; id register ignores writes
   // Only the two low data bits are kept; the rest read as zero
   // and writes to them are dropped
   always @(posedge clk or negedge rst_s_q)
   begin
      if (!rst_s_q)
         ctrl_q <= `TPID_CTRL_RST;
      else if (reg_wr && reg_addr == `TPID_OFS_CTRL)
         ctrl_q <= reg_wdata[1:0];
   end

   // Port selects follow the control bits only once test reset released
   // Gating with the synced test reset keeps both selects low for as
   // long as the far side holds the port in reset
   always @(posedge clk or negedge rst_s_q)
   begin
      if (!rst_s_q)
      begin
         emu_sel   <= 1'b0;
         bscan_sel <= 1'b0;
      end
      else
      begin
         emu_sel   <= ctrl_q[0] & trst_s;
         bscan_sel <= ctrl_q[1] & trst_s;
      end
   end

   // Read data in the cycle after the strobe; unmapped reads as zero
   // Status word: bit 8 synced test reset, bits 7:4 instruction,
   // bits 3:0 controller state
   always @(posedge clk or negedge rst_s_q)
   begin
      if (!rst_s_q)
         reg_rdata <= 32'h00000000;
      else if (reg_rd)
      begin
         case (reg_addr)
            `TPID_OFS_ID:     reg_rdata <= id_word;
            `TPID_OFS_STATUS: reg_rdata <= {23'h000000, trst_s, ir_q, st_q};
            `TPID_OFS_CTRL:   reg_rdata <= {30'h00000000, ctrl_q};
            default:          reg_rdata <= 32'h00000000;
         endcase
      end
      else
         reg_rdata <= 32'h00000000;
   end

endmodule

// *** test/tpid_top_chk.sv ***
// Checker for the test port identification block
`timescale 1ns/100ps
`include "tpid_defines.vh"
module tpid_top_chk
#(
   parameter [3:0]  VARIANT = 4'h0,
   parameter [15:0] PART    = 16'h0000,
   parameter [10:0] MFR     = 11'h000
)
(
   // Clock and reset
   input wire        clk,
   input wire        rst_b,
   // Link pins
   input wire        tck,
   input wire        trst_b,
   input wire        tdo,
   input wire        tdo_oe,
   // Register port
   input wire [3:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata,
   // Selects
   input wire        emu_sel,
   input wire        bscan_sel
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Id read request
   wire rd_id = reg_rd && reg_addr == `TPID_OFS_ID;
   AST_VARIANT: assert property (rd_id |=> reg_rdata[31:28] == VARIANT)
      else $error("variant field wrong");
   AST_PART: assert property (rd_id |=> reg_rdata[27:12] == PART)
      else $error("part field wrong");
   AST_MFR: assert property (rd_id |=> reg_rdata[11:1] == MFR)
      else $error("maker field wrong");
   AST_ONE: assert property (rd_id |=> reg_rdata[0])
      else $error("low id bit not one");
   AST_RO: assert property (reg_wr && reg_addr == `TPID_OFS_ID ##[1:3] rd_id |=>
      reg_rdata == {VARIANT, PART, MFR, 1'b1}) else $error("id changed by write");
   AST_IDLE0: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   // Sync takes about three cycles, so six is safe
   AST_TRST: assert property (!trst_b [*6] |-> !tdo_oe && !emu_sel && !bscan_sel)
      else $error("port active in test reset");
   AST_SEL: assert property (reg_wr && reg_addr == `TPID_OFS_CTRL ##1 trst_b [*6] |=>
      emu_sel == $past(reg_wdata[0], 7) && bscan_sel == $past(reg_wdata[1], 7))
      else $error("select not following control");
   // Data out moves only in the low phase of the link clock
   AST_TDO: assert property (trst_b && $changed(tdo) |-> !$past(tck, 2))
      else $error("data out moved in high phase");
   cover property (rd_id);
   cover property ($rose(tdo_oe));
   cover property ($rose(emu_sel) && !bscan_sel);
endmodule
bind tpid_top tpid_top_chk #(.VARIANT(VARIANT), .PART(PART), .MFR(MFR)) i_tpid_top_chk
(
   .clk(clk), .rst_b(rst_b), .tck(tck), .trst_b(trst_b), .tdo(tdo), .tdo_oe(tdo_oe),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .emu_sel(emu_sel), .bscan_sel(bscan_sel)
);

// *** test/tpid_ctrl_model.sv ***
// Model of the external test controller on the link
`timescale 1ns/100ps
module tpid_ctrl_model
(
   // Link pins
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_b,
   input  wire  tdo,
   input  wire  tdo_oe
);
   // Power-up state
   initial
   begin
      tck    = 1'b0;  // Stands still between frames
      tms    = 1'b1;
      tdi    = 1'b0;
      trst_b = 1'b0;
   end
   // One 125 ns link period; data out taken late in the low phase
   task automatic step(input logic m, input logic d, output logic o);
   begin
      tms = m;
      tdi = d;
      // A released line shows the inverse, so a missing enable is caught
      #55.0 o = tdo_oe ? tdo : ~tdo;
      #7.5 tck = 1'b1;
      #62.5 tck = 1'b0;
   end
   endtask
   // Released only while access is wanted
   task automatic set_reset(input logic v);
   begin
      trst_b = v;
   end
   endtask
endmodule

// *** test/tpid_top_test.sv ***
// Self-checking bench for the test port identification block
`timescale 1ns/100ps
`include "tpid_defines.vh"
module tpid_top_test;
   localparam logic [31:0] ID_WORD = {`TPID_VARIANT_RST, `TPID_PART_RST, `TPID_MFR_RST, 1'b1};
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   wire  [31:0] reg_rdata;
   wire         tck, tms, tdi, trst_b, tdo, tdo_oe, emu_sel, bscan_sel;
   int          mismatches = 0;
   int          total_checks = 0;
   int          cycles = 0;
   logic        bit_q;
   logic [31:0] shifted;
   always #5 clk = ~clk;
   tpid_top i_tpid_top (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b),
      .tdo(tdo), .tdo_oe(tdo_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .emu_sel(emu_sel), .bscan_sel(bscan_sel));
   tpid_ctrl_model i_tpid_ctrl_model (.tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b), .tdo(tdo),
      .tdo_oe(tdo_oe));
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
   begin
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   end
   endtask
   // One-cycle write
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
   begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   end
   endtask
   // Read; data stands only in the following cycle
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
   begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   end
   endtask
   // One link period with data in low, mode select as given
   task automatic mv(input logic m);
   begin
      i_tpid_ctrl_model.step(m, 1'b0, bit_q);
   end
   endtask
   // Shift n bits LSB first, leaving the shift state on the last one
   task automatic shift_bits(input int n, input logic [31:0] d);
   begin
      for (int i = 0; i < n; i++)
      begin
         i_tpid_ctrl_model.step(i == n - 1, d[i], bit_q);
         shifted[i] = bit_q;
      end
   end
   endtask
   task automatic tally_and_finish;
   begin
      $display("Checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   // Hang guard, well above the roughly 800 cycles needed
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(4'h0, ID_WORD);
      wr(4'h0, 32'hFFFF_FFFF);
      rdc(4'h0, ID_WORD);
      wr(4'h1, 32'hFFFF_FFFF);
      rdc(4'h1, 32'h0000_0010);
      rdc(4'h2, 32'h0000_0003);
      rdc(4'hF, 32'h0000_0000);
      check({30'h0, bscan_sel, emu_sel}, 32'h0);
      i_tpid_ctrl_model.set_reset(1'b1);
      // Every control combination
      for (int v = 0; v < 4; v++)
      begin
         wr(4'h2, 32'(v));
         repeat (8) @(posedge clk);
         #1 check({30'h0, bscan_sel, emu_sel}, 32'(v));
      end
      // Walk to the data shift state
      i_tpid_ctrl_model.step(1'b0, 1'b0, bit_q);
      i_tpid_ctrl_model.step(1'b1, 1'b0, bit_q);
      i_tpid_ctrl_model.step(1'b0, 1'b0, bit_q);
      i_tpid_ctrl_model.step(1'b0, 1'b0, bit_q);
      for (int i = 0; i < 32; i++)
      begin
         i_tpid_ctrl_model.step(i == 31, 1'b1, bit_q);
         shifted[i] = bit_q;
      end
      check(shifted, ID_WORD);
      check({31'h0, tdo_oe}, 32'h1);
      mv(1'b1);
      check({31'h0, tdo_oe}, 32'h0);
      mv(1'b0);
      rdc(4'h1, 32'h0000_0111);
      // Instruction scan: capture pattern out, bypass code in
      mv(1'b1);
      mv(1'b1);
      mv(1'b0);
      mv(1'b0);
      shift_bits(4, 32'h0000_000F);
      check({28'h0, shifted[3:0]}, {28'h0, `TPID_IR_CAPTURE});
      mv(1'b1);
      mv(1'b0);
      rdc(4'h1, {23'h0, 1'b1, `TPID_IR_BYPASS, 4'h1});
      // Bypass: a zero captured, then the data in delayed by one stage
      mv(1'b1);
      mv(1'b0);
      mv(1'b0);
      shift_bits(4, 32'h0000_000D);
      check({28'h0, shifted[3:0]}, 32'h0000_000A);
      mv(1'b1);
      mv(1'b0);
      i_tpid_ctrl_model.set_reset(1'b0);
      repeat (8) @(posedge clk);
      rdc(4'h1, 32'h0000_0010);
      check({30'h0, bscan_sel, emu_sel}, 32'h0);
      tally_and_finish();
   end
endmodule
